// File: rtl/center_aligned_pwm_concat.sv
// Purpose: eight channel pwm, left or center aligned, pairs joinable
//          into 16-bit channels, emergency shutdown from channel 7 input
// Assumes: apb slave, one wait state on every access
// Notes:   counter tick is clk (select 0) or the prescaled tick (select 1)
//
// Operation
// RQ1: alignment select one puts a channel into center-aligned mode.
// RQ2: center mode counts up and down, direction forced up at zero.
// RQ3: center mode toggles output at duty match, going up and down.
// RQ4: center mode reverses to counting down at period match.
// RQ5: reaching zero downward turns up and loads buffered period, duty.
// RQ6: center mode counts zero to period and back, twice the period.
// RQ7: software picks alignment before enabling a channel.
// RQ8: four join bits each merge one channel pair into 16 bits.
// RQ9: even channel holds high bytes, odd channel holds low bytes.
// RQ10: joined pair uses odd channel clock select and output pin.
// RQ11: joined pair uses odd channel polarity, even polarity ignored.
// RQ12: only odd enable runs joined pair; even output stays disabled.
// RQ13: any byte write to a joined counter clears all 16 bits.
// RQ14: software reads a joined counter in one access; the code returns one byte per access, so it takes two.
// RQ15: joined pair uses odd channel alignment bit only.
// RQ16: software changes join bits only with both channels disabled.
// RQ17: duty zero gives inverse polarity, duty at least period gives it.
// RQ18: period zero holds counter at zero, output equals polarity.
// RQ19: after reset counters count up, channels disabled, not counting.
// RQ20: channel 7 changes or enable edge set flag; irq gated by enable.
// RQ21: in low power modes shutdown forces outputs but sets no flag.
// RQ22: period and duty double buffered, direct while disabled.
// RQ23: polarity one starts high, falls at duty; zero starts low.
// RQ24: counter write clears, counts up, loads buffers, sets output.
`timescale 1ns/1ns

module center_aligned_pwm_concat
  import pwm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire apb_req_t         apb_req,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             channel_seven_pin,
  input  wire logic             stop_mode,
  input  wire logic             wait_mode,
  output logic [NUM_CH-1:0]     channel_output_pin,
  output logic                  shutdown_irq
);

  // ---------------------------------------------------------------
  // step of one counter by one tick
  // ---------------------------------------------------------------
  // works on 16 bits; 8-bit channels pass zero-extended values
  function automatic step_t step(input logic [15:0] c,
                                 input logic        up,
                                 input logic [15:0] p,
                                 input logic [15:0] d,
                                 input logic        ctr);
    step_t s;
    s.cnt  = c;
    s.up   = up;
    s.tog  = 1'b0;
    s.load = 1'b0;
    // RQ18 period zero holds
    if (p == RST_WORD) begin
      s.cnt  = RST_WORD;
      s.up   = 1'b1;
      s.load = 1'b1;
    end else if (!ctr) begin
      // left aligned: 0 .. period-1 then restart
      if (c >= p - 16'h0001) begin
        s.cnt  = RST_WORD;
        s.load = 1'b1;
      end else begin
        s.cnt = c + 16'h0001;
      end
      s.up = 1'b1;
    end else if (up) begin
      // RQ4 reverse at period
      if (c >= p) begin
        s.up  = 1'b0;
        s.cnt = c - 16'h0001;
      end else begin
        s.cnt = c + 16'h0001;
      end
    end else begin
      s.cnt = (c == RST_WORD) ? RST_WORD : c - 16'h0001;
      // RQ2 RQ5 up again at zero
      if (s.cnt == RST_WORD) begin
        s.up   = 1'b1;
        s.load = 1'b1;
      end
    end
    // RQ3 toggle on duty match
    s.tog = (s.cnt == d) && !s.load && (p != RST_WORD);
    return s;
  endfunction

  // pin level from phase with boundary overrides
  function automatic logic level(input logic        ph,
                                 input logic        pol,
                                 input logic [15:0] p,
                                 input logic [15:0] d);
    logic l;
    // RQ23 polarity sets start level
    l = pol ^ ph;
    // RQ17 RQ18 boundary levels
    if (p == RST_WORD)
      l = pol;
    else if (d == RST_WORD)
      l = ~pol;
    else if (d >= p)
      l = pol;
    return l;
  endfunction

  // ---------------------------------------------------------------
  // registers and bus decode
  // ---------------------------------------------------------------
  logic [7:0]  channel_enable_bit_q;
  logic [7:0]  channel_polarity_bit_q;
  logic [7:0]  channel_clock_select_q;
  logic [7:0]  alignment_select_bank_q;
  logic [3:0]  pair_join_bit_q;
  logic [7:0]  prescale_q;
  logic        shutdown_input_enable_q;
  logic        module_output_enable_q;
  logic        shutdown_active_level_q;
  logic        shutdown_level_q;
  logic        shutdown_irq_enable_q;
  logic        shutdown_irq_flag_q;
  logic        wait_mode_stop_bit_q;
  logic [7:0]  channel_period_value_q [NUM_CH];
  logic [7:0]  channel_duty_value_q   [NUM_CH];
  logic [7:0]  cnt_byte               [NUM_CH];
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  wire         acc      = apb_req.psel & apb_req.penable;
  wire         acc_new  = acc & ~pready_q;
  wire         do_wr    = acc & pready_q & apb_req.pwrite;
  wire [7:0]   addr     = apb_req.paddr;
  wire [7:0]   wbyte    = apb_req.pwdata[7:0];
  wire [2:0]   idx      = addr[4:2];
  wire         aligned  = (addr[1:0] == 2'b00);
  wire         in_per   = aligned && (addr[7:5] == SEL_PERIOD);
  wire         in_dty   = aligned && (addr[7:5] == SEL_DUTY);
  wire         in_cnt   = aligned && (addr[7:5] == SEL_COUNT);
  wire         hit_en   = (addr == OFS_ENABLE);
  wire         hit_pol  = (addr == OFS_POLARITY);
  wire         hit_sel  = (addr == OFS_CLKSEL);
  wire         hit_aln  = (addr == OFS_ALIGN);
  wire         hit_join = (addr == OFS_JOIN);
  wire         hit_pre  = (addr == OFS_PRESCALE);
  wire         hit_sdn  = (addr == OFS_SHUTDOWN);
  wire         mapped   = hit_en | hit_pol | hit_sel | hit_aln | hit_join
                        | hit_pre | hit_sdn | in_per | in_dty | in_cnt;
  wire [7:0]   wr_cnt   = (do_wr && in_cnt) ? (8'h01 << idx) : 8'h00;

  // shutdown status byte, pin state read only, flag cleared by writing one
  logic [7:0]  sdn_byte;
  logic        pin_s2_q;

  // read selection, if chain over the map
  logic [7:0]  rd_byte;
  always_comb begin
    sdn_byte                = RST_BYTE;
    sdn_byte[SDN_INEN_BIT]  = shutdown_input_enable_q;
    sdn_byte[SDN_MODEN_BIT] = module_output_enable_q;
    sdn_byte[SDN_ACT_BIT]   = shutdown_active_level_q;
    sdn_byte[SDN_PIN_BIT]   = pin_s2_q;
    sdn_byte[SDN_LVL_BIT]   = shutdown_level_q;
    sdn_byte[SDN_WSTOP_BIT] = wait_mode_stop_bit_q;
    sdn_byte[SDN_IRQEN_BIT] = shutdown_irq_enable_q;
    sdn_byte[SDN_FLAG_BIT]  = shutdown_irq_flag_q;
    if (hit_en)
      rd_byte = channel_enable_bit_q;
    else if (hit_pol)
      rd_byte = channel_polarity_bit_q;
    else if (hit_sel)
      rd_byte = channel_clock_select_q;
    else if (hit_aln)
      rd_byte = alignment_select_bank_q;
    else if (hit_join)
      rd_byte = {4'h0, pair_join_bit_q};
    else if (hit_pre)
      rd_byte = prescale_q;
    else if (hit_sdn)
      rd_byte = sdn_byte;
    else if (in_per)
      rd_byte = channel_period_value_q[idx];
    else if (in_dty)
      rd_byte = channel_duty_value_q[idx];
    else if (in_cnt)
      rd_byte = cnt_byte[idx];
    else
      rd_byte = RST_BYTE;
  end

  // one wait state keeps every bus output registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= RST_RDATA;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_new;
      pslverr_q <= acc_new & ~mapped;
      if (acc_new)
        prdata_q <= {24'h000000, rd_byte};
    end
  end

  // control registers; RQ19 all channels off after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_enable_bit_q    <= RST_BYTE;
      channel_polarity_bit_q  <= RST_BYTE;
      channel_clock_select_q  <= RST_BYTE;
      alignment_select_bank_q <= RST_BYTE;
      pair_join_bit_q         <= 4'h0;
      prescale_q              <= RST_BYTE;
      shutdown_input_enable_q <= 1'b0;
      module_output_enable_q  <= 1'b0;
      shutdown_active_level_q <= 1'b0;
      shutdown_level_q        <= 1'b0;
      shutdown_irq_enable_q   <= 1'b0;
    end else if (do_wr) begin
      if (hit_en)
        channel_enable_bit_q <= wbyte;
      if (hit_pol)
        channel_polarity_bit_q <= wbyte;
      if (hit_sel)
        channel_clock_select_q <= wbyte;
      if (hit_aln)
        alignment_select_bank_q <= wbyte;
      // RQ8 four join bits
      if (hit_join)
        pair_join_bit_q <= wbyte[3:0];
      if (hit_pre)
        prescale_q <= wbyte;
      if (hit_sdn) begin
        shutdown_input_enable_q <= wbyte[SDN_INEN_BIT];
        module_output_enable_q  <= wbyte[SDN_MODEN_BIT];
        shutdown_active_level_q <= wbyte[SDN_ACT_BIT];
        shutdown_level_q        <= wbyte[SDN_LVL_BIT];
        shutdown_irq_enable_q   <= wbyte[SDN_IRQEN_BIT];
      end
    end
  end

  // RQ22 buffers always take the write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_period_value_q[i] <= RST_BYTE;
        channel_duty_value_q[i]   <= RST_BYTE;
      end
    end else if (do_wr) begin
      if (in_per)
        channel_period_value_q[idx] <= wbyte;
      if (in_dty)
        channel_duty_value_q[idx] <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // tick sources
  // ---------------------------------------------------------------
  logic [7:0]  presc_cnt_q;
  logic        tick_b_q;

  // prescaled tick every prescale+1 clocks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc_cnt_q <= RST_BYTE;
      tick_b_q    <= 1'b0;
    end else begin
      tick_b_q    <= (presc_cnt_q >= prescale_q);
      presc_cnt_q <= (presc_cnt_q >= prescale_q) ? RST_BYTE
                                                 : presc_cnt_q + 8'h01;
    end
  end

  wire [7:0] tick = channel_enable_bit_q
                  & (channel_clock_select_q & {8{tick_b_q}}
                     | ~channel_clock_select_q);

  // ---------------------------------------------------------------
  // channel pairs: h=0 is the odd (low byte) channel
  // ---------------------------------------------------------------
  logic [7:0] pin_d;

  for (genvar g = 0; g < NUM_PAIR; g++) begin : pair
    localparam int LO = 2 * g + 1;
    localparam int HI = 2 * g;
    logic [15:0] cnt_q, cnt_d, per_q, per_d, dty_q, dty_d;
    logic [1:0]  up_q, up_d, ph_q, ph_d;
    step_t       s16;
    step_t       s8 [2];
    wire         wide  = pair_join_bit_q[g];
    wire [15:0]  bper  = {channel_period_value_q[HI],
                          channel_period_value_q[LO]};
    wire [15:0]  bdty  = {channel_duty_value_q[HI],
                          channel_duty_value_q[LO]};

    // RQ9 RQ10 RQ15 even bytes high, odd channel controls
    assign s16 = step(cnt_q, up_q[0], per_q, dty_q,
                      alignment_select_bank_q[LO]);
    // RQ1 per-channel alignment in 8-bit mode
    for (genvar h = 0; h < 2; h++) begin : half
      assign s8[h] = step({8'h00, cnt_q[8*h +: 8]}, up_q[h],
                          {8'h00, per_q[8*h +: 8]},
                          {8'h00, dty_q[8*h +: 8]},
                          alignment_select_bank_q[LO-h]);
    end

    assign cnt_byte[HI] = cnt_q[15:8];
    assign cnt_byte[LO] = cnt_q[7:0];

    // next state of both counters
    always_comb begin
      cnt_d = cnt_q;
      per_d = per_q;
      dty_d = dty_q;
      up_d  = up_q;
      ph_d  = ph_q;
      if (wide) begin
        // RQ13 RQ24 any byte write clears all 16 bits
        if (wr_cnt[HI] | wr_cnt[LO]) begin
          cnt_d = RST_WORD;
          up_d  = 2'b11;
          ph_d  = 2'b00;
          per_d = bper;
          dty_d = bdty;
        // RQ12 odd enable alone runs the pair
        end else if (!channel_enable_bit_q[LO]) begin
          per_d = bper;
          dty_d = bdty;
        end else if (tick[LO]) begin
          cnt_d    = s16.cnt;
          up_d[0]  = s16.up;
          ph_d[0]  = s16.load ? 1'b0 : ph_q[0] ^ s16.tog;
          if (s16.load) begin
            per_d = bper;
            dty_d = bdty;
          end
        end
      end else begin
        for (int h = 0; h < 2; h++) begin
          // RQ24 counter write restarts the channel
          if (wr_cnt[LO-h]) begin
            cnt_d[8*h +: 8] = RST_BYTE;
            up_d[h]         = 1'b1;
            ph_d[h]         = 1'b0;
            per_d[8*h +: 8] = bper[8*h +: 8];
            dty_d[8*h +: 8] = bdty[8*h +: 8];
          // RQ22 write-through while disabled
          end else if (!channel_enable_bit_q[LO-h]) begin
            per_d[8*h +: 8] = bper[8*h +: 8];
            dty_d[8*h +: 8] = bdty[8*h +: 8];
          // RQ6 RQ22 new values only at period end
          end else if (tick[LO-h]) begin
            cnt_d[8*h +: 8] = s8[h].cnt[7:0];
            up_d[h]         = s8[h].up;
            ph_d[h]         = s8[h].load ? 1'b0 : ph_q[h] ^ s8[h].tog;
            if (s8[h].load) begin
              per_d[8*h +: 8] = bper[8*h +: 8];
              dty_d[8*h +: 8] = bdty[8*h +: 8];
            end
          end
        end
      end
    end

    // RQ19 count up and hold after reset
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q <= RST_WORD;
        per_q <= RST_WORD;
        dty_q <= RST_WORD;
        up_q  <= 2'b11;
        ph_q  <= 2'b00;
      end else begin
        cnt_q <= cnt_d;
        per_q <= per_d;
        dty_q <= dty_d;
        up_q  <= up_d;
        ph_q  <= ph_d;
      end
    end

    // RQ11 RQ12 odd polarity, even output off when joined
    assign pin_d[LO] = !channel_enable_bit_q[LO] ? 1'b0 :
                       wide ? level(ph_q[0], channel_polarity_bit_q[LO],
                                    per_q, dty_q)
                            : level(ph_q[0], channel_polarity_bit_q[LO],
                                    {8'h00, per_q[7:0]},
                                    {8'h00, dty_q[7:0]});
    assign pin_d[HI] = (wide || !channel_enable_bit_q[HI]) ? 1'b0 :
                       level(ph_q[1], channel_polarity_bit_q[HI],
                             {8'h00, per_q[15:8]}, {8'h00, dty_q[15:8]});
  end

  // ---------------------------------------------------------------
  // emergency shutdown
  // ---------------------------------------------------------------
  logic pin_s1_q;
  logic pin_s3_q;
  logic moden_prev_q;
  logic [7:0] pin_q;
  logic irq_q;

  // pin is asynchronous, so two flops before anything looks at it
  wire sdn_active = shutdown_input_enable_q
                  & (pin_s2_q == shutdown_active_level_q);
  wire low_power  = stop_mode | (wait_mode & wait_mode_stop_bit_q);
  // RQ20 pin change or enable edge with pin active
  wire flag_set   = ~low_power
                  & ((shutdown_input_enable_q & (pin_s2_q ^ pin_s3_q))
                     | (module_output_enable_q & ~moden_prev_q
                        & (pin_s2_q == shutdown_active_level_q)));
  wire flag_clr   = do_wr & hit_sdn & wbyte[SDN_FLAG_BIT];

  // wait-stop bit of the shutdown register, reads back too
  always_ff @(posedge clk) begin
    if (!rst_n)
      wait_mode_stop_bit_q <= 1'b0;
    else if (do_wr && hit_sdn)
      wait_mode_stop_bit_q <= wbyte[SDN_WSTOP_BIT];
  end

  // synchroniser, edge history and sticky flag; set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_q            <= 1'b0;
      pin_s2_q            <= 1'b0;
      pin_s3_q            <= 1'b0;
      moden_prev_q        <= 1'b0;
      shutdown_irq_flag_q <= 1'b0;
      irq_q               <= 1'b0;
    end else begin
      pin_s1_q            <= channel_seven_pin;
      pin_s2_q            <= pin_s1_q;
      pin_s3_q            <= pin_s2_q;
      moden_prev_q        <= module_output_enable_q;
      // RQ21 no flag in low power
      shutdown_irq_flag_q <= flag_set | (shutdown_irq_flag_q & ~flag_clr);
      irq_q               <= shutdown_irq_flag_q & shutdown_irq_enable_q;
    end
  end

  // RQ21 shutdown forces levels in every mode
  always_ff @(posedge clk) begin
    if (!rst_n)
      pin_q <= RST_BYTE;
    else
      pin_q <= sdn_active ? {8{shutdown_level_q}} : pin_d;
  end

  assign channel_output_pin = pin_q;
  assign shutdown_irq       = irq_q;
  assign pready             = pready_q;
  assign prdata             = prdata_q;
  assign pslverr            = pslverr_q;

endmodule

// File: rtl/pwm_pkg.sv
// Purpose: shared constants and carriers of the eight channel modulator
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   byte addresses below are the low 8 bits of paddr
package pwm_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH   = 8;
  localparam int NUM_PAIR = 4;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_CLKSEL   = 8'h08;
  localparam logic [7:0] OFS_ALIGN    = 8'h0c;
  localparam logic [7:0] OFS_JOIN     = 8'h10;
  localparam logic [7:0] OFS_PRESCALE = 8'h14;
  localparam logic [7:0] OFS_SHUTDOWN = 8'h18;
  // upper three address bits select the per-channel register arrays
  localparam logic [2:0] SEL_PERIOD   = 3'h1;
  localparam logic [2:0] SEL_DUTY     = 3'h2;
  localparam logic [2:0] SEL_COUNT    = 3'h3;

  // ---------------------------------------------------------------
  // shutdown register fields
  // ---------------------------------------------------------------
  localparam int SDN_INEN_BIT  = 0;
  localparam int SDN_MODEN_BIT = 1;
  localparam int SDN_ACT_BIT   = 2;
  localparam int SDN_PIN_BIT   = 3;
  localparam int SDN_LVL_BIT   = 4;
  localparam int SDN_WSTOP_BIT = 5;
  localparam int SDN_IRQEN_BIT = 6;
  localparam int SDN_FLAG_BIT  = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        up;
    logic        tog;
    logic        load;
  } step_t;

endpackage

// File: sim/pwm_load.sv
// Purpose: load model on the modulated pins, tallies level and edges
// Assumes: pins are registered levels, sampled on the rising edge
// Notes:   clr empties every tally at the next edge
`timescale 1ns/1ns

module pwm_load (
  input  wire logic       clk,
  input  wire logic [7:0] pins,
  input  wire logic       clr,
  output int              hi_cnt [8],
  output int              rise_cnt [8]
);
  logic [7:0] prev_q;

  // a load sees levels only, so the edge tally stands in for period
  always_ff @(posedge clk) begin
    prev_q <= pins;
    for (int i = 0; i < 8; i++) begin
      hi_cnt[i]   <= clr ? 0 : hi_cnt[i] + int'(pins[i]);
      rise_cnt[i] <= clr ? 0 : rise_cnt[i] + int'(pins[i] > prev_q[i]);
    end
  end
endmodule

// File: sim/pwm_asserts.sv
// Purpose: port level checks of the pwm block
// Assumes: the master holds each request until pready
// Notes:   enable, join and shutdown bytes shadowed from bus writes
`timescale 1ns/1ns

module pwm_asserts
  import pwm_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire apb_req_t          apb_req,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              channel_seven_pin,
  input wire logic              stop_mode,
  input wire logic              wait_mode,
  input wire logic [NUM_CH-1:0] channel_output_pin,
  input wire logic              shutdown_irq
);
  logic [7:0] en_q, sd_q, offa_q, offb_q;
  logic [3:0] join_q;
  logic [2:0] sdh_q;
  wire logic       wr_ok;
  wire logic       quiet;
  wire logic [7:0] ev_m;

  // accepted write, even pins of joined pairs, no shutdown lately
  assign wr_ok = apb_req.psel & apb_req.penable & apb_req.pwrite
               & pready & ~pslverr;
  assign ev_m  = {1'b0, join_q[3], 1'b0, join_q[2],
                  1'b0, join_q[1], 1'b0, join_q[0]};
  assign quiet = ~sd_q[SDN_INEN_BIT] & (sdh_q == 3'h0);

  // shadow bytes update on the same edge as the block's own
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q   <= 8'h00;
      join_q <= 4'h0;
      sd_q   <= 8'h00;
    end else if (wr_ok) begin
      if (apb_req.paddr == OFS_ENABLE)   en_q   <= apb_req.pwdata[7:0];
      if (apb_req.paddr == OFS_JOIN)     join_q <= apb_req.pwdata[3:0];
      if (apb_req.paddr == OFS_SHUTDOWN) sd_q   <= apb_req.pwdata[7:0];
    end
  end

  // two cycles of enable history and three of shutdown history give the pin pipeline room to settle
  always_ff @(posedge clk) begin
    sdh_q  <= {sdh_q[1:0], sd_q[SDN_INEN_BIT]};
    offa_q <= ~en_q;
    offb_q <= offa_q & ~en_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // setup cycle followed by the access cycle
  sequence s_req;
    apb_req.psel && !apb_req.penable ##1 apb_req.penable && !pready;
  endsequence

  AST_READY_ONE_WAIT: assert property (s_req |=> pready)
    else $error("pready late after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_BYTE: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_RESET_QUIET:
    assert property ($rose(rst_n) |-> channel_output_pin == 8'h00)
    else $error("pins active after reset");
  AST_OFF_PIN_LOW:
    assert property (quiet |-> (channel_output_pin & offb_q) == 8'h00)
    else $error("disabled channel drives its pin");
  AST_JOIN_EVEN_LOW:
    assert property (quiet |-> (channel_output_pin & ev_m) == 8'h00)
    else $error("joined high channel drives its pin");
  AST_IRQ_GATED:
    assert property (shutdown_irq |-> $past(sd_q[SDN_IRQEN_BIT]))
    else $error("interrupt without its enable");
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench of the eight channel pwm
// Assumes: clock select 0, so every channel steps on each clk
// Notes:   level and edge tallies over 512 clocks stand for waveforms
`timescale 1ns/1ns

module testbench
  import pwm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n, clr, pin7, stop_m, wait_m, er, pready, pslverr, irq;
  logic [31:0] prdata, rd;
  logic [7:0]  pins, sd;
  apb_req_t    req;
  int          hi_cnt [8], rise_cnt [8];
  int          mismatches = 0;
  int          comparisons = 0;

  always #10 clk = ~clk;

  center_aligned_pwm_concat uut (
    .clk(clk), .rst_n(rst_n), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .channel_seven_pin(pin7),
    .stop_mode(stop_m), .wait_mode(wait_m),
    .channel_output_pin(pins), .shutdown_irq(irq));
  pwm_load load (.clk(clk), .pins(pins), .clr(clr),
    .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle; answer taken at the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  // high clocks in 512 for a given period, duty and polarity
  function automatic int hic(input int p, input int d, input logic pl);
    if (p == 0) return pl ? 512 : 0;
    if (d > p) d = p;
    return 512 * (pl ? d : p - d) / p;
  endfunction

  // random widths, joins and modes, then tally every pin
  task automatic round();
    logic [7:0] pl, ca, en, pb [8], db [8];
    logic [3:0] jn;
    int         p [8], d [8], q, r;
    jn = 4'($urandom);
    pl = 8'($urandom);
    ca = 8'($urandom);
    en = 8'($urandom);
    for (int i = 0; i < 8; i++) begin
      p[i]  = $urandom_range(4) == 0 ? 0 : 1 << $urandom_range(3);
      d[i]  = $urandom_range(p[i] + 1);
      pb[i] = 8'(p[i]);
      db[i] = 8'(d[i]);
      if (jn[i/2] && i % 2 == 1) begin
        p[i]    = 256;
        d[i]    = $urandom_range(257);
        pb[i-1] = 8'h01;
        pb[i]   = 8'h00;
        db[i-1] = 8'(d[i] >> 8);
        db[i]   = 8'(d[i]);
      end
    end
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_JOIN, {4'h0, jn});
    wr(OFS_POLARITY, pl);
    wr(OFS_ALIGN, ca);
    for (int i = 0; i < 8; i++) begin
      wr({SEL_PERIOD, 3'(i), 2'b00}, pb[i]);
      wr({SEL_DUTY, 3'(i), 2'b00}, db[i]);
      wr({SEL_COUNT, 3'(i), 2'b00}, 8'($urandom));
    end
    wr(OFS_ENABLE, en);
    repeat (40) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (512) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      q = (en[i] && !(jn[i/2] && i % 2 == 0)) ? 1 : 0;
      chk(32'(hi_cnt[i]), 32'(q * hic(p[i], d[i], pl[i])));
      r = (q && d[i] > 0 && d[i] < p[i]) ? (ca[i] ? 256 : 512) / p[i] : 0;
      chk(32'(rise_cnt[i]), 32'(r));
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog, well beyond the planned run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // main sequence
  initial begin
    req    = '0;
    rst_n  = 1'b0;
    clr    = 1'b0;
    pin7   = 1'b0;
    stop_m = 1'b0;
    wait_m = 1'b0;
    void'($urandom(25800));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // every register idle after reset, the hole at 0x1c refused
    for (int a = 0; a < 128; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, er}, {31'h0, a == 28});
    end
    chk({24'h0, pins}, 32'h0);
    repeat (8) round();
    // shutdown forces pins in every mode, flags only in run mode
    for (int m = 0; m < 3; m++) begin
      sd = (m == 2) ? 8'h75 : 8'h55;
      wr(OFS_SHUTDOWN, sd);
      stop_m <= (m == 1);
      wait_m <= (m == 2);
      pin7   <= 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk({24'h0, pins}, 32'hff);
      chk({31'h0, irq}, {31'h0, m == 0});
      apb(1'b0, OFS_SHUTDOWN, 32'h0);
      chk(rd, {24'h0, sd | 8'h08 | (m == 0 ? 8'h80 : 8'h00)});
      pin7 <= 1'b0;
      repeat (5) @(posedge clk);
      wr(OFS_SHUTDOWN, sd | 8'h80);
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    // module enable raised while the pin sits at its active level
    wr(OFS_SHUTDOWN, 8'h44);
    wait_m <= 1'b0;
    pin7   <= 1'b1;
    repeat (4) @(posedge clk);
    wr(OFS_SHUTDOWN, 8'h46);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    report_and_stop();
  end
endmodule

bind center_aligned_pwm_concat pwm_asserts chk_i (
  .clk, .rst_n, .apb_req, .pready, .prdata, .pslverr,
  .channel_seven_pin, .stop_mode, .wait_mode,
  .channel_output_pin, .shutdown_irq);
